// *** common/tpwm_pkg.sv ***
// constants, types and field layout of the two-channel timer and pwm unit
// Behaviour
// - a counter write with sync selected presets every synchronized counter together.
// - a sync-clear channel clears whenever any other synchronized channel clears.
// - each channel has its own sync select bit.
// - channel 1 counter is upper half, channel 2 lower half of 32 bits.
// - prescale select of channel 1 set to cascade counts channel 2 overflows.
// - simultaneous pin A captures in cascade store upper and lower halves.
// - in normal mode each compare match drives its pin low, high or toggles.
// - pwm mode per channel, works with sync; clear source match sets period.
// - pwm mode 1 drives pin A only; match A and B apply their levels.
// - pwm mode 1 pin A starts at match A initial level.
// - pwm mode 1 with equal A and B values keeps pin unchanged.
// - pwm mode 1 gives at most two phases, channel 1 and 2 pin A.
// - pwm mode 2 uses period register plus duty registers driving configured levels.
// - pwm mode 2 period clear returns each pwm pin to its initial level.
// - pwm mode 2 duty equal to period leaves that pin unchanged.
// - pwm mode 2 two phases on pin A; period register and B drive nothing.
// - match and overflow sources, each with own flag and own enable.
// - source sets flag; request while flag and enable high, gone when flag cleared.
// - fixed priority: ch1 A, ch1 B, ch1 overflow, ch2 A, ch2 B, ch2 overflow.
// - four match requests and two overflow requests.
// - counter wrap from all ones sets overflow flag and keeps counting.
// - counter counts only while its start bit is 1.
`default_nettype none
package tpwm_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // global registers
  localparam logic [4:0] OFS_START   = 5'h00;
  localparam logic [4:0] OFS_SYNC    = 5'h01;
  // per-channel blocks of eight registers
  localparam logic [4:0] OFS_CH1     = 5'h02;
  localparam logic [4:0] OFS_CH2     = 5'h0A;
  localparam logic [4:0] OFS_CH_SPAN = 5'h08;
  localparam logic [2:0] REL_CTRL    = 3'h0;
  localparam logic [2:0] REL_MODE    = 3'h1;
  localparam logic [2:0] REL_IO      = 3'h2;
  localparam logic [2:0] REL_IE      = 3'h3;
  localparam logic [2:0] REL_STAT    = 3'h4;
  localparam logic [2:0] REL_CNT     = 3'h5;
  localparam logic [2:0] REL_MA      = 3'h6;
  localparam logic [2:0] REL_MB      = 3'h7;

  // timer_control_register fields
  localparam int CTRL_PSC_LSB = 0;
  localparam int CTRL_CLR_LSB = 3;
  localparam logic [2:0] PSC_DIV1    = 3'h0;
  localparam logic [2:0] PSC_DIV4    = 3'h1;
  localparam logic [2:0] PSC_DIV16   = 3'h2;
  localparam logic [2:0] PSC_DIV64   = 3'h3;
  localparam logic [2:0] PSC_CASCADE = 3'h7;
  localparam logic [1:0] CLR_NONE    = 2'h0;
  localparam logic [1:0] CLR_MA      = 2'h1;
  localparam logic [1:0] CLR_MB      = 2'h2;
  localparam logic [1:0] CLR_SYNC    = 2'h3;

  // io_control_register: pin_a_output_select low nibble, pin_b_output_select high
  localparam int IO_B_LSB    = 4;
  localparam int IO_INIT_BIT = 2;
  localparam int IO_CAP_BIT  = 3;
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_LOW    = 2'h1;
  localparam logic [1:0] ACT_HIGH   = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // status / enable bit positions in the register word
  localparam int BIT_A   = 0;
  localparam int BIT_B   = 1;
  localparam int BIT_OVF = 4;

  // reset values
  localparam logic [15:0] CNT_RST   = 16'h0000;
  localparam logic [15:0] MATCH_RST = 16'hFFFF;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic [5:0]  PRE_RST   = 6'h00;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_PWM1   = 2'b01,
    MODE_PWM2   = 2'b10
  } tpwm_mode_t;

  // flags and enables: index 0 match A, 1 match B, 2 overflow
  typedef struct packed {
    logic [2:0] psc;
    logic [1:0] clr;
    tpwm_mode_t mode;
    logic [3:0] io_a;
    logic [3:0] io_b;
    logic [2:0] ie;
  } tpwm_cfg_t;

  localparam tpwm_cfg_t CFG_RST = '{psc: PSC_DIV1, clr: CLR_NONE, mode: MODE_NORMAL,
                                    io_a: 4'h0, io_b: 4'h0, ie: 3'h0};

  typedef struct packed {
    logic       hit;
    logic       ch;
    logic [2:0] rel;
  } tpwm_dec_t;
endpackage
`default_nettype wire

// *** hdl/tpwm_top.sv ***
// two-channel 16-bit timer with sync, cascade, pwm modes and interrupt flags
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module tpwm_top (
  input  wire logic        SYS_CLK_IN,
  input  wire logic        SYS_RST_IN,
  input  wire logic [4:0]  REG_ADDR_IN,
  input  wire logic [15:0] REG_WDATA_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic        REG_RD_IN,
  output logic [15:0]      REG_RDATA_OUT,
  input  wire logic [1:0]  CAPTURE_COMPARE_PIN_A_IN,
  output logic [1:0]       CAPTURE_COMPARE_PIN_A_OUT,
  output logic [1:0]       CAPTURE_COMPARE_PIN_A_OE_N_OUT,
  input  wire logic [1:0]  CAPTURE_COMPARE_PIN_B_IN,
  output logic [1:0]       CAPTURE_COMPARE_PIN_B_OUT,
  output logic [1:0]       CAPTURE_COMPARE_PIN_B_OE_N_OUT,
  output logic             CH1_A_MATCH_REQUEST_OUT,
  output logic             CH1_B_MATCH_REQUEST_OUT,
  output logic             CH1_OVERFLOW_REQUEST_OUT,
  output logic             CH2_A_MATCH_REQUEST_OUT,
  output logic             CH2_B_MATCH_REQUEST_OUT,
  output logic             CH2_OVERFLOW_REQUEST_OUT,
  output logic [2:0]       IRQ_SOURCE_OUT
);

  function automatic tpwm_pkg::tpwm_dec_t decode(input logic [4:0] a);
    tpwm_pkg::tpwm_dec_t d;
    logic [4:0]          off;
    d   = '{hit: 1'b0, ch: 1'b0, rel: 3'h0};
    off = 5'h00;
    if (a >= tpwm_pkg::OFS_CH1 && a < tpwm_pkg::OFS_CH2)
    begin
      off = a - tpwm_pkg::OFS_CH1;
      d   = '{hit: 1'b1, ch: 1'b0, rel: off[2:0]};
    end
    else if (a >= tpwm_pkg::OFS_CH2 && a < tpwm_pkg::OFS_CH2 + tpwm_pkg::OFS_CH_SPAN)
    begin
      off = a - tpwm_pkg::OFS_CH2;
      d   = '{hit: 1'b1, ch: 1'b1, rel: off[2:0]};
    end
    return d;
  endfunction

  function automatic logic apply_act(input logic [1:0] act, input logic cur);
    logic r;
    case (act)
      tpwm_pkg::ACT_LOW:    r = 1'b0;
      tpwm_pkg::ACT_HIGH:   r = 1'b1;
      tpwm_pkg::ACT_TOGGLE: r = ~cur;
      default:              r = cur;
    endcase
    return r;
  endfunction

  function automatic logic [15:0] flags_to_word(input logic [2:0] f);
    logic [15:0] w;
    w                   = 16'h0000;
    w[tpwm_pkg::BIT_A]   = f[0];
    w[tpwm_pkg::BIT_B]   = f[1];
    w[tpwm_pkg::BIT_OVF] = f[2];
    return w;
  endfunction

  function automatic logic [2:0] word_to_flags(input logic [15:0] w);
    return {w[tpwm_pkg::BIT_OVF], w[tpwm_pkg::BIT_B], w[tpwm_pkg::BIT_A]};
  endfunction

  logic [1:0]          start_ff;
  logic [1:0]          sync_ff;
  tpwm_pkg::tpwm_cfg_t cfg_ff     [2];
  logic [15:0]         cnt_ff     [2];
  logic [15:0]         ma_ff      [2];
  logic [15:0]         mb_ff      [2];
  logic [2:0]          flag_ff    [2];
  logic [2:0]          seen_ff    [2];
  logic [1:0]          pin_a_ff;
  logic [1:0]          pin_b_ff;
  logic [1:0]          oe_a_n_ff;
  logic [1:0]          oe_b_n_ff;
  logic [1:0]          prev_a_ff;
  logic [1:0]          prev_b_ff;
  logic [5:0]          pre_ff;
  logic [15:0]         rdata_ff;
  logic [5:0]          req_ff;
  logic [2:0]          src_ff;

  tpwm_pkg::tpwm_dec_t wdec;
  tpwm_pkg::tpwm_dec_t rdec;
  logic [1:0]          tick;
  logic [1:0]          en;
  logic [1:0]          cmp_a;
  logic [1:0]          cmp_b;
  logic [1:0]          cap_a;
  logic [1:0]          cap_b;
  logic [1:0]          own_clr;
  logic [1:0]          clr;
  logic [1:0]          wr_cnt;
  logic [1:0]          ovf;
  logic                any_sync_clr;
  logic                sync_preset;
  logic                ch2_wrap;
  logic [15:0]         nxt_cnt    [2];
  logic [2:0]          nxt_flag   [2];
  logic [1:0]          nxt_pin_a;
  logic [1:0]          nxt_oe_a_n;
  logic [1:0]          nxt_oe_b_n;
  logic [5:0]          nxt_req;

  assign wdec = decode(REG_ADDR_IN);
  assign rdec = decode(REG_ADDR_IN);

  // channel 2 wrap ignores clearing so that cascade never forms a loop via sync clear
  assign ch2_wrap    = start_ff[1] & tick[1] & (cnt_ff[1] == tpwm_pkg::CNT_MAX);
  assign sync_preset = REG_WR_IN & wdec.hit & (wdec.rel == tpwm_pkg::REL_CNT) & sync_ff[wdec.ch];

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      case (cfg_ff[c].psc)
        tpwm_pkg::PSC_DIV1:    tick[c] = 1'b1;
        tpwm_pkg::PSC_DIV4:    tick[c] = (pre_ff[1:0] == 2'h3);
        tpwm_pkg::PSC_DIV16:   tick[c] = (pre_ff[3:0] == 4'hF);
        tpwm_pkg::PSC_DIV64:   tick[c] = (pre_ff == 6'h3F);
        tpwm_pkg::PSC_CASCADE: tick[c] = (c == 0) ? ch2_wrap : 1'b0;
        default:               tick[c] = 1'b0;
      endcase
      en[c] = start_ff[c] & tick[c];
    end
  end

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      logic pwm;
      logic wr_ma;
      logic wr_mb;
      pwm   = (cfg_ff[c].mode != tpwm_pkg::MODE_NORMAL);
      wr_ma = REG_WR_IN & wdec.hit & (wdec.ch == 1'(c)) & (wdec.rel == tpwm_pkg::REL_MA);
      wr_mb = REG_WR_IN & wdec.hit & (wdec.ch == 1'(c)) & (wdec.rel == tpwm_pkg::REL_MB);
      // a match register write suppresses that register's compare in the same cycle
      cmp_a[c] = en[c] & (cnt_ff[c] == ma_ff[c]) & ~wr_ma
               & (pwm | ~cfg_ff[c].io_a[tpwm_pkg::IO_CAP_BIT]);
      cmp_b[c] = en[c] & (cnt_ff[c] == mb_ff[c]) & ~wr_mb
               & (pwm | ~cfg_ff[c].io_b[tpwm_pkg::IO_CAP_BIT]);
      cap_a[c] = ~pwm & cfg_ff[c].io_a[tpwm_pkg::IO_CAP_BIT]
               & (cfg_ff[c].io_a[tpwm_pkg::IO_INIT_BIT]
                  ? (prev_a_ff[c] & ~CAPTURE_COMPARE_PIN_A_IN[c])
                  : (~prev_a_ff[c] & CAPTURE_COMPARE_PIN_A_IN[c]));
      cap_b[c] = ~pwm & cfg_ff[c].io_b[tpwm_pkg::IO_CAP_BIT]
               & (cfg_ff[c].io_b[tpwm_pkg::IO_INIT_BIT]
                  ? (prev_b_ff[c] & ~CAPTURE_COMPARE_PIN_B_IN[c])
                  : (~prev_b_ff[c] & CAPTURE_COMPARE_PIN_B_IN[c]));
      own_clr[c] = ((cfg_ff[c].clr == tpwm_pkg::CLR_MA) & (cmp_a[c] | cap_a[c]))
                 | ((cfg_ff[c].clr == tpwm_pkg::CLR_MB) & (cmp_b[c] | cap_b[c]));
    end
  end

  assign any_sync_clr = |(own_clr & sync_ff);

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      clr[c] = own_clr[c]
             | (sync_ff[c] & (cfg_ff[c].clr == tpwm_pkg::CLR_SYNC) & any_sync_clr);
      wr_cnt[c] = (REG_WR_IN & wdec.hit & (wdec.ch == 1'(c))
                   & (wdec.rel == tpwm_pkg::REL_CNT))
                | (sync_preset & sync_ff[c]);
      // clear beats write, write beats increment; overflow lost to either
      ovf[c] = en[c] & (cnt_ff[c] == tpwm_pkg::CNT_MAX) & ~clr[c] & ~wr_cnt[c];
      if (clr[c])
        nxt_cnt[c] = tpwm_pkg::CNT_RST;
      else if (wr_cnt[c])
        nxt_cnt[c] = REG_WDATA_IN;
      else if (en[c])
        nxt_cnt[c] = cnt_ff[c] + 16'h0001;
      else
        nxt_cnt[c] = cnt_ff[c];
    end
  end

  // flags: hardware set wins over a software clear in the same cycle
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      logic [2:0] set;
      logic [2:0] wipe;
      set  = {ovf[c], cmp_b[c] | cap_b[c], cmp_a[c] | cap_a[c]};
      wipe = 3'h0;
      if (REG_WR_IN & wdec.hit & (wdec.ch == 1'(c)) & (wdec.rel == tpwm_pkg::REL_STAT))
        wipe = seen_ff[c] & ~word_to_flags(REG_WDATA_IN);
      nxt_flag[c] = set | (flag_ff[c] & ~wipe);
    end
  end

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      logic [15:0] period;
      logic        init_a;
      logic        same;
      init_a = cfg_ff[c].io_a[tpwm_pkg::IO_INIT_BIT];
      same   = 1'b0;
      period = ma_ff[c];
      if (cfg_ff[c].clr == tpwm_pkg::CLR_MB)
        period = mb_ff[c];
      else if (cfg_ff[c].clr == tpwm_pkg::CLR_SYNC)
        period = (cfg_ff[1 - c].clr == tpwm_pkg::CLR_MB) ? mb_ff[1 - c] : ma_ff[1 - c];
      nxt_pin_a[c]  = pin_a_ff[c];
      nxt_oe_a_n[c] = cfg_ff[c].io_a[tpwm_pkg::IO_CAP_BIT];
      nxt_oe_b_n[c] = 1'b1;
      case (cfg_ff[c].mode)
        tpwm_pkg::MODE_PWM1:
        begin
          same = (ma_ff[c] == mb_ff[c]);
          nxt_oe_a_n[c] = 1'b0;
          if (!start_ff[c])
            nxt_pin_a[c] = init_a;
          else if (same)
            nxt_pin_a[c] = pin_a_ff[c];
          else if (cmp_a[c])
            nxt_pin_a[c] = apply_act(cfg_ff[c].io_a[1:0], pin_a_ff[c]);
          else if (cmp_b[c])
            nxt_pin_a[c] = apply_act(cfg_ff[c].io_b[1:0], pin_a_ff[c]);
        end
        tpwm_pkg::MODE_PWM2:
        begin
          same = (ma_ff[c] == period);
          // the period register owns no pin
          nxt_oe_a_n[c] = (cfg_ff[c].clr == tpwm_pkg::CLR_MA);
          if (!start_ff[c])
            nxt_pin_a[c] = init_a;
          else if (same)
            nxt_pin_a[c] = pin_a_ff[c];
          else if (clr[c])
            nxt_pin_a[c] = init_a;
          else if (cmp_a[c])
            nxt_pin_a[c] = apply_act(cfg_ff[c].io_a[1:0], pin_a_ff[c]);
        end
        default:
        begin
          nxt_oe_b_n[c] = cfg_ff[c].io_b[tpwm_pkg::IO_CAP_BIT];
          if (!start_ff[c])
            nxt_pin_a[c] = init_a;
          else if (cmp_a[c])
            nxt_pin_a[c] = apply_act(cfg_ff[c].io_a[1:0], pin_a_ff[c]);
        end
      endcase
    end
  end

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      nxt_req[3 * c]     = nxt_flag[c][0] & cfg_ff[c].ie[0];
      nxt_req[3 * c + 1] = nxt_flag[c][1] & cfg_ff[c].ie[1];
      nxt_req[3 * c + 2] = nxt_flag[c][2] & cfg_ff[c].ie[2];
    end
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      pre_ff <= tpwm_pkg::PRE_RST;
    else
      pre_ff <= pre_ff + 6'h01;
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      start_ff <= 2'h0;
      sync_ff  <= 2'h0;
      for (int c = 0; c < 2; c++)
        cfg_ff[c] <= tpwm_pkg::CFG_RST;
    end
    else if (REG_WR_IN)
    begin
      if (REG_ADDR_IN == tpwm_pkg::OFS_START)
        start_ff <= REG_WDATA_IN[1:0];
      if (REG_ADDR_IN == tpwm_pkg::OFS_SYNC)
        sync_ff <= REG_WDATA_IN[1:0];
      if (wdec.hit)
      begin
        case (wdec.rel)
          tpwm_pkg::REL_CTRL:
          begin
            cfg_ff[wdec.ch].psc <= REG_WDATA_IN[tpwm_pkg::CTRL_PSC_LSB +: 3];
            cfg_ff[wdec.ch].clr <= REG_WDATA_IN[tpwm_pkg::CTRL_CLR_LSB +: 2];
          end
          tpwm_pkg::REL_MODE:
            cfg_ff[wdec.ch].mode <= tpwm_pkg::tpwm_mode_t'(REG_WDATA_IN[1:0]);
          tpwm_pkg::REL_IO:
          begin
            cfg_ff[wdec.ch].io_a <= REG_WDATA_IN[3:0];
            cfg_ff[wdec.ch].io_b <= REG_WDATA_IN[tpwm_pkg::IO_B_LSB +: 4];
          end
          tpwm_pkg::REL_IE:
            cfg_ff[wdec.ch].ie <= word_to_flags(REG_WDATA_IN);
          default:
            cfg_ff[wdec.ch] <= cfg_ff[wdec.ch];
        endcase
      end
    end
  end

  // counters and match registers; capture beats a same-cycle register write
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      for (int c = 0; c < 2; c++)
      begin
        cnt_ff[c] <= tpwm_pkg::CNT_RST;
        ma_ff[c]  <= tpwm_pkg::MATCH_RST;
        mb_ff[c]  <= tpwm_pkg::MATCH_RST;
      end
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        cnt_ff[c] <= nxt_cnt[c];
        if (cap_a[c])
          ma_ff[c] <= cnt_ff[c];
        else if (REG_WR_IN & wdec.hit & (wdec.ch == 1'(c)) & (wdec.rel == tpwm_pkg::REL_MA))
          ma_ff[c] <= REG_WDATA_IN;
        if (cap_b[c])
          mb_ff[c] <= cnt_ff[c];
        else if (REG_WR_IN & wdec.hit & (wdec.ch == 1'(c)) & (wdec.rel == tpwm_pkg::REL_MB))
          mb_ff[c] <= REG_WDATA_IN;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      for (int c = 0; c < 2; c++)
      begin
        flag_ff[c] <= 3'h0;
        seen_ff[c] <= 3'h0;
      end
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        flag_ff[c] <= nxt_flag[c];
        // a flag must be seen high by a read before a zero write may clear it
        if (REG_RD_IN & rdec.hit & (rdec.ch == 1'(c)) & (rdec.rel == tpwm_pkg::REL_STAT))
          seen_ff[c] <= seen_ff[c] | flag_ff[c];
        else
          seen_ff[c] <= seen_ff[c] & nxt_flag[c];
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      pin_a_ff  <= 2'h0;
      pin_b_ff  <= 2'h0;
      oe_a_n_ff <= 2'h3;
      oe_b_n_ff <= 2'h3;
      prev_a_ff <= 2'h0;
      prev_b_ff <= 2'h0;
    end
    else
    begin
      pin_a_ff  <= nxt_pin_a;
      oe_a_n_ff <= nxt_oe_a_n;
      oe_b_n_ff <= nxt_oe_b_n;
      prev_a_ff <= CAPTURE_COMPARE_PIN_A_IN;
      prev_b_ff <= CAPTURE_COMPARE_PIN_B_IN;
      for (int c = 0; c < 2; c++)
      begin
        // pin B only drives in normal compare mode
        if (!start_ff[c])
          pin_b_ff[c] <= cfg_ff[c].io_b[tpwm_pkg::IO_INIT_BIT];
        else if (cfg_ff[c].mode == tpwm_pkg::MODE_NORMAL && cmp_b[c])
          pin_b_ff[c] <= apply_act(cfg_ff[c].io_b[1:0], pin_b_ff[c]);
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      req_ff <= 6'h00;
      src_ff <= 3'h0;
    end
    else
    begin
      req_ff <= nxt_req;
      src_ff <= 3'h0;
      for (int i = 5; i >= 0; i--)
        if (nxt_req[i])
          src_ff <= 3'(i + 1);
    end
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      rdata_ff <= 16'h0000;
    else if (!REG_RD_IN)
      rdata_ff <= 16'h0000;
    else if (REG_ADDR_IN == tpwm_pkg::OFS_START)
      rdata_ff <= {14'h0000, start_ff};
    else if (REG_ADDR_IN == tpwm_pkg::OFS_SYNC)
      rdata_ff <= {14'h0000, sync_ff};
    else if (rdec.hit)
    begin
      case (rdec.rel)
        tpwm_pkg::REL_CTRL: rdata_ff <= {11'h000, cfg_ff[rdec.ch].clr, cfg_ff[rdec.ch].psc};
        tpwm_pkg::REL_MODE: rdata_ff <= {14'h0000, cfg_ff[rdec.ch].mode};
        tpwm_pkg::REL_IO:   rdata_ff <= {8'h00, cfg_ff[rdec.ch].io_b, cfg_ff[rdec.ch].io_a};
        tpwm_pkg::REL_IE:   rdata_ff <= flags_to_word(cfg_ff[rdec.ch].ie);
        tpwm_pkg::REL_STAT: rdata_ff <= flags_to_word(flag_ff[rdec.ch]);
        tpwm_pkg::REL_CNT:  rdata_ff <= cnt_ff[rdec.ch];
        tpwm_pkg::REL_MA:   rdata_ff <= ma_ff[rdec.ch];
        default:            rdata_ff <= mb_ff[rdec.ch];
      endcase
    end
    else
      rdata_ff <= 16'h0000;
  end

  assign REG_RDATA_OUT                  = rdata_ff;
  assign CAPTURE_COMPARE_PIN_A_OUT      = pin_a_ff;
  assign CAPTURE_COMPARE_PIN_A_OE_N_OUT = oe_a_n_ff;
  assign CAPTURE_COMPARE_PIN_B_OUT      = pin_b_ff;
  assign CAPTURE_COMPARE_PIN_B_OE_N_OUT = oe_b_n_ff;
  assign CH1_A_MATCH_REQUEST_OUT        = req_ff[0];
  assign CH1_B_MATCH_REQUEST_OUT        = req_ff[1];
  assign CH1_OVERFLOW_REQUEST_OUT       = req_ff[2];
  assign CH2_A_MATCH_REQUEST_OUT        = req_ff[3];
  assign CH2_B_MATCH_REQUEST_OUT        = req_ff[4];
  assign CH2_OVERFLOW_REQUEST_OUT       = req_ff[5];
  assign IRQ_SOURCE_OUT                 = src_ff;

endmodule
`default_nettype wire

// *** testbench/tpwm_checker.sv ***
// port assertions for the two-channel timer and pwm unit
`timescale 1ns/100ps
`default_nettype none
module tpwm_checker (
  input wire logic        SYS_CLK_IN,
  input wire logic        SYS_RST_IN,
  input wire logic [4:0]  REG_ADDR_IN,
  input wire logic        REG_WR_IN,
  input wire logic        REG_RD_IN,
  input wire logic [15:0] REG_RDATA_OUT,
  input wire logic        CH1_A_MATCH_REQUEST_OUT,
  input wire logic        CH1_B_MATCH_REQUEST_OUT,
  input wire logic        CH1_OVERFLOW_REQUEST_OUT,
  input wire logic        CH2_A_MATCH_REQUEST_OUT,
  input wire logic        CH2_B_MATCH_REQUEST_OUT,
  input wire logic        CH2_OVERFLOW_REQUEST_OUT,
  input wire logic [2:0]  IRQ_SOURCE_OUT
);
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  logic [5:0] rq;
  assign rq = {CH2_OVERFLOW_REQUEST_OUT, CH2_B_MATCH_REQUEST_OUT, CH2_A_MATCH_REQUEST_OUT,
               CH1_OVERFLOW_REQUEST_OUT, CH1_B_MATCH_REQUEST_OUT, CH1_A_MATCH_REQUEST_OUT};
  // the source code registers in the same cycle as the requests, from the same next requests
  a_prio_ch1a: assert property ($stable(rq) && rq[0] |-> IRQ_SOURCE_OUT == 3'h1)
    else $error("ch1 a request not ranked first");
  a_prio_ch1b: assert property ($stable(rq) && rq[1:0] == 2'h2 |-> IRQ_SOURCE_OUT == 3'h2)
    else $error("ch1 b request misranked");
  a_prio_ovf1: assert property ($stable(rq) && rq[2:0] == 3'h4 |-> IRQ_SOURCE_OUT == 3'h3)
    else $error("ch1 overflow request misranked");
  a_prio_ch2a: assert property ($stable(rq) && rq[3:0] == 4'h8 |-> IRQ_SOURCE_OUT == 3'h4)
    else $error("ch2 a request misranked");
  a_prio_low: assert property ($stable(rq) && rq == 6'h20 |-> IRQ_SOURCE_OUT == 3'h6)
    else $error("ch2 overflow request misranked");
  a_prio_none: assert property ($stable(rq) && rq == 6'h00 |-> IRQ_SOURCE_OUT == 3'h0)
    else $error("source shown with no request");
  a_rdata_idle: assert property (!REG_RD_IN |=> REG_RDATA_OUT == 16'h0000)
    else $error("read data outside the read answer cycle");
  a_unmapped_read: assert property (REG_RD_IN && REG_ADDR_IN > 5'h11 |=> REG_RDATA_OUT == 16'h0000)
    else $error("unmapped read returned data");
  a_req_drop1: assert property ($fell(rq[0]) |-> $past(REG_WR_IN)
                                && $past(REG_ADDR_IN) inside {5'h05, 5'h06})
    else $error("ch1 a request dropped without a clear");
  a_req_drop2: assert property ($fell(rq[5]) |-> $past(REG_WR_IN)
                                && $past(REG_ADDR_IN) inside {5'h0D, 5'h0E})
    else $error("ch2 overflow request dropped without a clear");
  c_two_req: cover property (rq[0] && rq[5]);
  c_low_src: cover property (IRQ_SOURCE_OUT == 3'h6);
  c_unmapped: cover property (REG_RD_IN && REG_ADDR_IN > 5'h11);
endmodule
bind tpwm_top tpwm_checker u_chk (.*);
`default_nettype wire

// *** testbench/tpwm_pin_model.sv ***
// external loads and capture sources on the four capture/compare pins
`timescale 1ns/100ps
`default_nettype none
module tpwm_pin_model (
  input  wire logic [3:0] oe_n_in,
  input  wire logic [3:0] drv_in,
  input  wire logic [3:0] src_in,
  output logic [3:0]      lvl_out
);
  // an undriven pin sees the source, which idles low like a pull-down
  assign lvl_out = (oe_n_in & src_in) | (~oe_n_in & drv_in);
endmodule
`default_nettype wire

// *** testbench/tpwm_top_test.sv ***
// self-checking bench for the two-channel timer and pwm unit
`timescale 1ns/100ps
`default_nettype none
module tpwm_top_test;
  logic        SYS_CLK_IN = 1'b0;
  logic        SYS_RST_IN = 1'b1;
  logic [4:0]  REG_ADDR_IN = 5'h00;
  logic [15:0] REG_WDATA_IN = 16'h0000;
  logic        REG_WR_IN = 1'b0;
  logic        REG_RD_IN = 1'b0;
  logic [15:0] REG_RDATA_OUT;
  logic [1:0]  CAPTURE_COMPARE_PIN_A_IN, CAPTURE_COMPARE_PIN_A_OUT;
  logic [1:0]  CAPTURE_COMPARE_PIN_B_IN, CAPTURE_COMPARE_PIN_B_OUT;
  logic [1:0]  CAPTURE_COMPARE_PIN_A_OE_N_OUT, CAPTURE_COMPARE_PIN_B_OE_N_OUT;
  logic        CH1_A_MATCH_REQUEST_OUT, CH1_B_MATCH_REQUEST_OUT, CH1_OVERFLOW_REQUEST_OUT;
  logic        CH2_A_MATCH_REQUEST_OUT, CH2_B_MATCH_REQUEST_OUT, CH2_OVERFLOW_REQUEST_OUT;
  logic [2:0]  IRQ_SOURCE_OUT;
  logic [3:0]  src = 4'h0;
  logic [31:0] seed = 32'h71E7;
  logic [31:0] exp;
  logic [15:0] d;
  int          n_fail = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          hi;
  tpwm_top u_dut (.*);
  tpwm_pin_model u_pins (
    .oe_n_in ({CAPTURE_COMPARE_PIN_B_OE_N_OUT, CAPTURE_COMPARE_PIN_A_OE_N_OUT}),
    .drv_in  ({CAPTURE_COMPARE_PIN_B_OUT, CAPTURE_COMPARE_PIN_A_OUT}),
    .src_in  (src),
    .lvl_out ({CAPTURE_COMPARE_PIN_B_IN, CAPTURE_COMPARE_PIN_A_IN})
  );
  always #2.5 SYS_CLK_IN = ~SYS_CLK_IN;
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction
  function automatic logic [4:0] ra(input logic ch, input logic [2:0] rel);
    return (ch ? tpwm_pkg::OFS_CH2 : tpwm_pkg::OFS_CH1) + {2'h0, rel};
  endfunction
  // 32-bit cascade value after n input ticks
  function automatic logic [31:0] casc(input logic [31:0] v, input int n);
    return v + 32'(n);
  endfunction
  task automatic report_and_stop;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic ck(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge SYS_CLK_IN);
    REG_WR_IN <= 1'b1;
    REG_ADDR_IN <= a;
    REG_WDATA_IN <= v;
    @(posedge SYS_CLK_IN);
    REG_WR_IN <= 1'b0;
    #1;
  endtask
  task automatic rc(input logic [4:0] a, input logic [15:0] want);
    @(posedge SYS_CLK_IN);
    REG_RD_IN <= 1'b1;
    REG_ADDR_IN <= a;
    @(posedge SYS_CLK_IN);
    REG_RD_IN <= 1'b0;
    #1 ck(REG_RDATA_OUT, want);
  endtask
  task automatic hicount(input int ch, input int n);
    hi = 0;
    repeat (n)
    begin
      @(posedge SYS_CLK_IN);
      #1 hi += int'(CAPTURE_COMPARE_PIN_A_OUT[ch]);
    end
  endtask
  always @(posedge SYS_CLK_IN)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      report_and_stop;
    end
  end
  initial
  begin
    repeat (20) @(posedge SYS_CLK_IN);
    SYS_RST_IN <= 1'b0;
    rc(ra(0, tpwm_pkg::REL_MA), 16'hFFFF);
    rc(ra(1, tpwm_pkg::REL_CNT), 16'h0000);
    rc(5'h15, 16'h0000);
    seed = nx(seed);
    wr(tpwm_pkg::OFS_SYNC, 16'h0003);
    wr(ra(0, tpwm_pkg::REL_CNT), seed[15:0]);
    rc(ra(1, tpwm_pkg::REL_CNT), seed[15:0]);
    wr(tpwm_pkg::OFS_SYNC, 16'h0001);
    wr(ra(0, tpwm_pkg::REL_CNT), ~seed[15:0]);
    rc(ra(1, tpwm_pkg::REL_CNT), seed[15:0]);
    wr(tpwm_pkg::OFS_SYNC, 16'h0000);
    // stopped counters make the captured halves exact
    seed = nx(seed);
    wr(ra(0, tpwm_pkg::REL_CNT), seed[31:16]);
    wr(ra(1, tpwm_pkg::REL_CNT), seed[15:0]);
    wr(ra(0, tpwm_pkg::REL_CTRL), 16'h0007);
    wr(ra(0, tpwm_pkg::REL_IO), 16'h0008);
    wr(ra(1, tpwm_pkg::REL_IO), 16'h0008);
    src <= 4'h3;
    repeat (4) @(posedge SYS_CLK_IN);
    src <= 4'h0;
    rc(ra(0, tpwm_pkg::REL_MA), seed[31:16]);
    rc(ra(1, tpwm_pkg::REL_MA), seed[15:0]);
    wr(ra(0, tpwm_pkg::REL_IE), 16'h0013);
    wr(ra(1, tpwm_pkg::REL_IE), 16'h0010);
    wr(ra(1, tpwm_pkg::REL_CNT), 16'hFFF0);
    wr(ra(0, tpwm_pkg::REL_CNT), 16'h0005);
    wr(tpwm_pkg::OFS_START, 16'h0003);
    repeat (31) @(posedge SYS_CLK_IN);
    wr(tpwm_pkg::OFS_START, 16'h0000);
    exp = casc(32'h0005FFF0, 33);
    rc(ra(0, tpwm_pkg::REL_CNT), exp[31:16]);
    rc(ra(1, tpwm_pkg::REL_CNT), exp[15:0]);
    ck(16'(IRQ_SOURCE_OUT), 16'h0001);
    wr(ra(0, tpwm_pkg::REL_STAT), 16'h0000);
    ck(16'(CH1_A_MATCH_REQUEST_OUT), 16'h0001);
    rc(ra(0, tpwm_pkg::REL_STAT), 16'h0001);
    wr(ra(0, tpwm_pkg::REL_STAT), 16'h0000);
    ck(16'(CH1_A_MATCH_REQUEST_OUT), 16'h0000);
    ck(16'(IRQ_SOURCE_OUT), 16'h0006);
    rc(ra(1, tpwm_pkg::REL_STAT), 16'h0013);
    wr(ra(1, tpwm_pkg::REL_STAT), 16'h0000);
    ck(16'(CH2_OVERFLOW_REQUEST_OUT), 16'h0000);
    wr(ra(0, tpwm_pkg::REL_CTRL), 16'h0008);
    wr(ra(0, tpwm_pkg::REL_MODE), 16'h0001);
    wr(ra(0, tpwm_pkg::REL_IO), 16'h0016);
    wr(ra(0, tpwm_pkg::REL_MA), 16'h0009);
    wr(ra(0, tpwm_pkg::REL_MB), 16'h0009);
    ck(16'(CAPTURE_COMPARE_PIN_A_OUT[0]), 16'h0001);
    wr(tpwm_pkg::OFS_START, 16'h0001);
    hicount(0, 40);
    ck(16'(hi), 16'd40);
    ck(16'(CAPTURE_COMPARE_PIN_B_OE_N_OUT[0]), 16'h0001);
    wr(ra(0, tpwm_pkg::REL_MB), 16'h0004);
    repeat (20) @(posedge SYS_CLK_IN);
    hicount(0, 40);
    ck(16'(hi), 16'd20);
    // ch2 pwm2 takes its period from the ch1 clear through sync clear
    wr(tpwm_pkg::OFS_SYNC, 16'h0003);
    wr(ra(1, tpwm_pkg::REL_CTRL), 16'h0018);
    wr(ra(1, tpwm_pkg::REL_MODE), 16'h0002);
    wr(ra(1, tpwm_pkg::REL_IO), 16'h0002);
    wr(ra(1, tpwm_pkg::REL_MA), 16'h0002);
    wr(tpwm_pkg::OFS_START, 16'h0003);
    repeat (20) @(posedge SYS_CLK_IN);
    hicount(1, 40);
    ck(16'(hi), 16'd28);
    ck(16'(CAPTURE_COMPARE_PIN_B_OE_N_OUT[1]), 16'h0001);
    // restart from the parked initial level
    wr(tpwm_pkg::OFS_START, 16'h0001);
    wr(ra(1, tpwm_pkg::REL_MA), 16'h0009);
    wr(tpwm_pkg::OFS_START, 16'h0003);
    hicount(1, 40);
    ck(16'(hi), 16'd0);
    report_and_stop;
  end
endmodule
`default_nettype wire
